// ---- or_return_rotate_exec.sv ----
// execution unit for idle, or, return and rotate-left instructions
// assumes synchronous memory with one-cycle read latency and a core-side stack
`timescale 1ns/1ps
`default_nettype none
module or_return_rotate_exec
	import exec_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// instruction request
	input wire logic op_valid,
	input wire exec_pkg::op_t op_code,
	input wire logic [exec_pkg::ADDR_W-1:0] op_addr,
	input wire logic [exec_pkg::DATA_W-1:0] op_literal,
	output logic op_ready,
	output logic op_done,
	// data memory port
	output logic mem_rd,
	output logic mem_wr,
	output logic [exec_pkg::ADDR_W-1:0] mem_addr,
	output logic [exec_pkg::DATA_W-1:0] mem_wdata,
	input wire logic [exec_pkg::DATA_W-1:0] mem_rdata,
	// return stack and program counter
	output logic stack_pop,
	input wire logic [exec_pkg::PC_W-1:0] stack_top,
	output logic [exec_pkg::PC_W-1:0] program_counter,
	// interrupt side
	input wire logic irq_pending,
	output logic irq_take,
	// architectural state
	output logic [exec_pkg::DATA_W-1:0] working_register,
	output logic zero_flag,
	output logic master_irq_enable
);
	import exec_pkg::*;

	state_t state;
	op_t held_op;
	logic [ADDR_W-1:0] held_addr;
	logic [PC_W-1:0] pc_plus_one;
	logic [DATA_W-1:0] or_result;
	logic [DATA_W-1:0] rot_result;
	logic needs_mem;
	logic accept;

	// ****************************************
	// decode and datapath
	// ****************************************
	// memory forms pause one cycle for the read data
	assign needs_mem = (op_code == OP_OR_MEM) || (op_code == OP_OR_INTO_MEM) || (op_code == OP_ROTATE_LEFT);
	assign op_ready = (state == ST_EXEC);
	assign accept = op_valid && op_ready;
	assign pc_plus_one = program_counter + 13'h0001;
	assign or_result = working_register | mem_rdata;
	assign rot_result = {mem_rdata[DATA_W-2:0], mem_rdata[DATA_W-1]};
	assign mem_rd = accept && needs_mem;
	assign mem_addr = (state == ST_MEM_WAIT) ? held_addr : op_addr;
	assign mem_wr = (state == ST_MEM_WAIT) && (held_op != OP_OR_MEM);
	assign mem_wdata = (held_op == OP_ROTATE_LEFT) ? rot_result : or_result;
	assign stack_pop = accept && (op_code == OP_SUB_EXIT || op_code == OP_EXIT_LIT || op_code == OP_INT_EXIT);

	// ****************************************
	// sequencer and architectural registers
	// ****************************************
	// pending interrupt is taken right after the return, before main code resumes
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state <= ST_EXEC;
			held_op <= OP_IDLE;
			held_addr <= '0;
			program_counter <= PC_RESET;
			working_register <= WREG_RESET;
			zero_flag <= ZERO_RESET;
			master_irq_enable <= MIE_RESET;
			op_done <= 1'b0;
			irq_take <= 1'b0;
		end else begin
			op_done <= 1'b0;
			irq_take <= 1'b0;
			case (state)
				ST_EXEC: begin
					if (accept) begin
						held_op <= op_code;
						held_addr <= op_addr;
						case (op_code)
							OP_IDLE: begin
								program_counter <= pc_plus_one;
								op_done <= 1'b1;
							end
							OP_OR_LIT: begin
								working_register <= working_register | op_literal;
								zero_flag <= ((working_register | op_literal) == '0);
								program_counter <= pc_plus_one;
								op_done <= 1'b1;
							end
							OP_SUB_EXIT: begin
								program_counter <= stack_top;
								op_done <= 1'b1;
							end
							OP_EXIT_LIT: begin
								program_counter <= stack_top;
								working_register <= op_literal;
								op_done <= 1'b1;
							end
							OP_INT_EXIT: begin
								program_counter <= stack_top;
								master_irq_enable <= 1'b1;
								op_done <= 1'b1;
								if (irq_pending) begin
									state <= ST_IRQ_ENTRY;
								end
							end
							OP_OR_MEM, OP_OR_INTO_MEM, OP_ROTATE_LEFT: begin
								state <= ST_MEM_WAIT; // read data arrives next cycle
							end
							default: begin
								// codes outside the set retire as idle rather than touch memory
								program_counter <= pc_plus_one;
								op_done <= 1'b1;
							end
						endcase
					end
				end
				ST_MEM_WAIT: begin
					if (held_op != OP_ROTATE_LEFT) begin
						zero_flag <= (or_result == '0);
					end
					if (held_op == OP_OR_MEM) begin
						working_register <= or_result;
					end
					program_counter <= pc_plus_one;
					op_done <= 1'b1;
					state <= ST_EXEC;
				end
				ST_IRQ_ENTRY: begin
					irq_take <= 1'b1;
					master_irq_enable <= 1'b0;
					state <= ST_EXEC;
				end
				default: begin
					state <= ST_EXEC;
				end
			endcase
		end
	end

	// ****************************************
	// checks
	// ****************************************
	// idle: only the program counter moves; nothing read, written or popped
	a_idle_keeps_state: assert property (@(posedge core_clk) disable iff (!rst_n)
		(accept && op_code == OP_IDLE) |=> ($stable(working_register) && $stable(zero_flag)
		&& program_counter == $past(program_counter) + 13'h0001 && !mem_wr))
		else $error("idle changed state");
	a_idle_no_access: assert property (@(posedge core_clk) disable iff (!rst_n)
		(accept && op_code == OP_IDLE) |-> (!mem_rd && !stack_pop))
		else $error("idle touched memory or stack");
	a_idle_irq_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		(accept && op_code == OP_IDLE) |=> ($stable(master_irq_enable) && !irq_take))
		else $error("idle changed interrupt state");
	// or forms: expectations built from the operands, not from the datapath wires
	a_or_lit_result: assert property (@(posedge core_clk) disable iff (!rst_n)
		(accept && op_code == OP_OR_LIT) |=> working_register == ($past(working_register) | $past(op_literal)))
		else $error("or literal wrong");
	a_or_lit_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
		(accept && op_code == OP_OR_LIT)
		|=> zero_flag == (($past(working_register) | $past(op_literal)) == 8'h00))
		else $error("or literal zero flag wrong");
	a_or_mem_read: assert property (@(posedge core_clk) disable iff (!rst_n)
		(accept && op_code == OP_OR_MEM) |-> (mem_rd && mem_addr == op_addr && !stack_pop))
		else $error("or memory read strobe wrong");
	a_or_mem_result: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state == ST_MEM_WAIT && held_op == OP_OR_MEM)
		|=> working_register == ($past(working_register) | $past(mem_rdata)))
		else $error("or memory wrong");
	a_or_mem_no_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state == ST_MEM_WAIT && held_op == OP_OR_MEM) |-> !mem_wr)
		else $error("or memory wrote memory");
	a_or_into_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state == ST_MEM_WAIT && held_op == OP_OR_INTO_MEM)
		|-> (mem_wr && mem_wdata == (working_register | mem_rdata)))
		else $error("or into memory wrong");
	a_or_into_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state == ST_MEM_WAIT && held_op == OP_OR_INTO_MEM) |=> $stable(working_register))
		else $error("or into memory changed working register");
	a_mem_read_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
		(accept && (op_code == OP_OR_INTO_MEM || op_code == OP_ROTATE_LEFT)) |-> (mem_rd && mem_addr == op_addr))
		else $error("memory form read strobe wrong");
	a_zero_flag_value: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state == ST_MEM_WAIT && held_op != OP_ROTATE_LEFT)
		|=> zero_flag == (($past(working_register) | $past(mem_rdata)) == 8'h00))
		else $error("zero flag wrong");
	// returns: the popped address is used as is, one pop per exit
	a_exit_pops_stack: assert property (@(posedge core_clk) disable iff (!rst_n)
		(accept && (op_code == OP_SUB_EXIT || op_code == OP_EXIT_LIT || op_code == OP_INT_EXIT))
		|-> (stack_pop && !mem_rd))
		else $error("exit did not pop");
	a_sub_exit_pc: assert property (@(posedge core_clk) disable iff (!rst_n)
		(accept && op_code == OP_SUB_EXIT) |=> (program_counter == $past(stack_top) && $stable(zero_flag)))
		else $error("subroutine exit wrong");
	a_sub_exit_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
		(accept && op_code == OP_SUB_EXIT) |=> ($stable(working_register) && $stable(master_irq_enable)))
		else $error("subroutine exit changed state");
	a_exit_lit_load: assert property (@(posedge core_clk) disable iff (!rst_n)
		(accept && op_code == OP_EXIT_LIT) |=> (working_register == $past(op_literal) && $stable(zero_flag)))
		else $error("exit with literal wrong");
	a_exit_lit_pc: assert property (@(posedge core_clk) disable iff (!rst_n)
		(accept && op_code == OP_EXIT_LIT) |=> program_counter == $past(stack_top))
		else $error("exit with literal address wrong");
	a_int_exit_mie: assert property (@(posedge core_clk) disable iff (!rst_n)
		(accept && op_code == OP_INT_EXIT) |=> (master_irq_enable && program_counter == $past(stack_top)))
		else $error("interrupt exit wrong");
	a_int_exit_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
		(accept && op_code == OP_INT_EXIT) |=> ($stable(working_register) && $stable(zero_flag)))
		else $error("interrupt exit changed state");
	// interrupt entry straight after the return when one waits, none otherwise
	a_pending_irq_taken: assert property (@(posedge core_clk) disable iff (!rst_n)
		(accept && op_code == OP_INT_EXIT && irq_pending) |=> !op_ready ##1 (irq_take && op_ready))
		else $error("pending interrupt not taken");
	a_no_irq_direct: assert property (@(posedge core_clk) disable iff (!rst_n)
		(accept && op_code == OP_INT_EXIT && !irq_pending) |=> op_ready ##1 !irq_take)
		else $error("interrupt entered without request");
	// rotate: memory rewritten, working register and flags untouched
	a_rotate_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state == ST_MEM_WAIT && held_op == OP_ROTATE_LEFT) |-> (mem_wr && mem_wdata == {mem_rdata[6:0], mem_rdata[7]})
		##1 $stable(zero_flag))
		else $error("rotate wrong");
	a_rotate_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state == ST_MEM_WAIT && held_op == OP_ROTATE_LEFT)
		|=> ($stable(working_register) && program_counter == $past(program_counter) + 13'h0001))
		else $error("rotate changed working register");
endmodule : or_return_rotate_exec
`default_nettype wire

// ---- exec_pkg.sv ----
// execution unit constants: opcodes, widths, reset values
// assumes a core that fetches, decodes and hands one instruction per request
package exec_pkg;
	// ****************************************
	// widths and reset values
	// ****************************************
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int PC_W = 13;
	localparam logic [DATA_W-1:0] WREG_RESET = 8'h00;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic ZERO_RESET = 1'b0;
	localparam logic MIE_RESET = 1'b0;
	// ****************************************
	// operation codes handed from decode, and sequencer states
	// ****************************************
	typedef enum logic [3:0] {
		OP_IDLE,
		OP_OR_MEM,
		OP_OR_LIT,
		OP_OR_INTO_MEM,
		OP_SUB_EXIT,
		OP_EXIT_LIT,
		OP_INT_EXIT,
		OP_ROTATE_LEFT
	} op_t;
	typedef enum logic [1:0] {
		ST_EXEC,
		ST_MEM_WAIT,
		ST_IRQ_ENTRY
	} state_t;
endpackage : exec_pkg

// ---- cpu_logic_return_rotate_exec_tb.sv ----
// bench for the idle, or, return and rotate-left execution unit
// assumes a one-cycle synchronous data memory, modelled here
`timescale 1ns/1ps
`default_nettype none
module cpu_logic_return_rotate_exec_tb;
	import exec_pkg::*;
	// ****************************************
	// stimulus, memory and expected state
	// ****************************************
	logic core_clk = 0, rst_n = 0, op_valid = 0, irq_pending = 0;
	op_t op_code = OP_IDLE;
	logic [7:0] op_addr = 8'h00, op_literal = 8'h00, mem_rdata = 8'h00, mem_wdata, mem_addr, working_register;
	logic [12:0] stack_top = 13'h0000, program_counter;
	logic op_ready, op_done, mem_rd, mem_wr, stack_pop, irq_take, zero_flag, master_irq_enable;
	logic [7:0] mem [256];
	logic [7:0] e_w = WREG_RESET;
	logic [12:0] e_pc = PC_RESET;
	logic e_z = ZERO_RESET, e_m = MIE_RESET;
	int miscompares = 0, samples_checked = 0, cycles = 0;
	or_return_rotate_exec u_or_return_rotate_exec (.core_clk(core_clk), .rst_n(rst_n), .op_valid(op_valid),
		.op_code(op_code), .op_addr(op_addr), .op_literal(op_literal), .op_ready(op_ready), .op_done(op_done),
		.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.stack_pop(stack_pop), .stack_top(stack_top), .program_counter(program_counter),
		.irq_pending(irq_pending), .irq_take(irq_take), .working_register(working_register),
		.zero_flag(zero_flag), .master_irq_enable(master_irq_enable));
	always #4 core_clk = ~core_clk;
	// memory reads every cycle so data is ready one edge after the read strobe
	always @(posedge core_clk) begin
		if (mem_wr) mem[mem_addr] <= mem_wdata;
		mem_rdata <= mem[mem_addr];
		cycles <= cycles + 1;
		if (cycles > 5000) begin
			miscompares++;
			give_verdict();
		end
	end
	function automatic logic [7:0] rotl(input logic [7:0] v);
		return {v[6:0], v[7]};
	endfunction : rotl
	function automatic logic is_mem(input op_t op);
		return op == OP_OR_MEM || op == OP_OR_INTO_MEM || op == OP_ROTATE_LEFT;
	endfunction : is_mem
	function automatic logic is_exit(input op_t op);
		return op == OP_SUB_EXIT || op == OP_EXIT_LIT || op == OP_INT_EXIT;
	endfunction : is_exit
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : give_verdict
	task automatic state_check();
		check("wreg", 16'(working_register), 16'(e_w));
		check("zero", 16'(zero_flag), 16'(e_z));
		check("pc", 16'(program_counter), 16'(e_pc));
		check("mie", 16'(master_irq_enable), 16'(e_m));
	endtask : state_check
	// one instruction: drive at falling edge, hold until taken, then compare
	task automatic run_op(input op_t op, input logic [7:0] a, input logic [7:0] l, input logic irq);
		logic [7:0] mv;
		logic [7:0] me;
		int n;
		mv = mem[a];
		me = mv;
		op_valid = 1;
		op_code = op;
		op_addr = a;
		op_literal = l;
		irq_pending = irq && op == OP_INT_EXIT;
		stack_top = 13'($urandom);
		n = 0;
		while (op_ready !== 1'b1 && n < 8) begin
			@(negedge core_clk);
			n++;
		end
		// strobes are combinational: let them settle before looking
		#1;
		check("mem_rd", 16'(mem_rd), 16'(is_mem(op)));
		check("stack_pop", 16'(stack_pop), 16'(is_exit(op)));
		check("mem_addr", 16'(mem_addr), 16'(a));
		@(negedge core_clk);
		// valid stays up; the next call replaces the request in this same step
		check("ready", 16'(op_ready), 16'(!is_mem(op) && !irq_pending));
		n = 0;
		while (op_done !== 1'b1 && n < 4) begin
			@(negedge core_clk);
			n++;
		end
		check("done", 16'(op_done), 16'h0001);
		check("irq_take quiet", 16'(irq_take), 16'h0000);
		e_pc = e_pc + 13'h0001;
		case (op)
			OP_OR_MEM: begin e_w = e_w | mv; e_z = e_w == 8'h00; end
			OP_OR_LIT: begin e_w = e_w | l; e_z = e_w == 8'h00; end
			OP_OR_INTO_MEM: begin me = e_w | mv; e_z = me == 8'h00; end
			OP_SUB_EXIT: e_pc = stack_top;
			OP_EXIT_LIT: begin e_pc = stack_top; e_w = l; end
			OP_INT_EXIT: begin e_pc = stack_top; e_m = 1'b1; end
			OP_ROTATE_LEFT: me = rotl(mv);
			default: ;
		endcase
		state_check();
		check("mem", 16'(mem[a]), 16'(me));
		if (irq_pending) begin
			@(negedge core_clk);
			e_m = 1'b0;
			check("irq_take", 16'(irq_take), 16'h0001);
			check("mie entry", 16'(master_irq_enable), 16'(e_m));
		end
	endtask : run_op
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(32'h570a2f08));
		for (int i = 0; i < 256; i++) mem[i] = 8'($urandom);
		mem[8'h10] = 8'h80;
		mem[8'h20] = 8'h00;
		repeat (3) @(negedge core_clk);
		rst_n = 1;
		state_check();
		// corner cases: zero results, bit 7 wrap, both exit paths of the interrupt return
		run_op(OP_OR_LIT, 8'h00, 8'h00, 1'b0);
		run_op(OP_OR_INTO_MEM, 8'h20, 8'h00, 1'b0);
		run_op(OP_ROTATE_LEFT, 8'h10, 8'h00, 1'b0);
		run_op(OP_INT_EXIT, 8'h00, 8'h00, 1'b1);
		run_op(OP_INT_EXIT, 8'h00, 8'h00, 1'b0);
		run_op(OP_EXIT_LIT, 8'h00, 8'h00, 1'b0);
		run_op(OP_OR_MEM, 8'h10, 8'h00, 1'b0);
		run_op(OP_IDLE, 8'h10, 8'hff, 1'b0);
		$display("corner cases done");
		repeat (300) run_op(op_t'($urandom_range(7)), 8'($urandom), 8'($urandom), 1'($urandom));
		$display("random ops done");
		give_verdict();
	end
endmodule : cpu_logic_return_rotate_exec_tb
`default_nettype wire
